// *** dv/cpt_timer_monitor.sv ***
// Port-level assertions for the compact timer.
`timescale 1ns/10ps
`include "cpt_consts.vh"

module cpt_timer_monitor (
   input wire        clk_i,
   input wire        rst_i,
   input wire        ce_i,
   input wire        cyc_i,
   input wire        stb_i,
   input wire        we_i,
   input wire [7:0]  adr_i,
   input wire [3:0]  sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   input wire        pin_o,
   input wire        pin_oe_o,
   input wire        match_a_flag_o,
   input wire        match_p_flag_o
);
   reg  [7:0] ctl1_q;
   reg        on_q;
   reg  [2:0] quiet_q;
   wire       wr;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////
   // Shadow of the control bits, taken at the edge a write lands.
   assign wr = cyc_i & stb_i & we_i & ack_o & sel_i[0] & ce_i;

   // Quiet counts edges since the last control write, so checks skip the
   // cycles in which the pin may still be settling on a new setting.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctl1_q  <= 8'h00;
         on_q    <= 1'b0;
         quiet_q <= 3'h0;
      end else begin
         if (wr && adr_i == `CPT_ADR_CTRL1) begin
            ctl1_q <= dat_i[7:0];
         end
         if (wr && adr_i == `CPT_ADR_CTRL0) begin
            on_q <= dat_i[`CPT_C0_ON];
         end
         if (wr && (adr_i == `CPT_ADR_CTRL0 || adr_i == `CPT_ADR_CTRL1)) begin
            quiet_q <= 3'h0;
         end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   ack_pulse_a:
      assert property (ack_o |=> !ack_o)
      else $error("ack held past one cycle");
   ack_answer_a:
      assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
      else $error("request not answered next cycle");
   read_upper_a:
      assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   flag_hold_a:
      assert property (match_a_flag_o && !(wr && adr_i == `CPT_ADR_FLAGS
         && dat_i[0]) |=> match_a_flag_o)
      else $error("match A flag lost without a clear");
   p_flag_off_a:
      assert property (ctl1_q[0] && ctl1_q[7:6] != `CPT_MODE_PWM
         && !match_p_flag_o |=> !match_p_flag_o)
      else $error("match P flag set with clear on A");
   pin_enable_a:
      assert property (!$past(rst_i) && ctl1_q[7:6] == $past(ctl1_q[7:6])
         |-> pin_oe_o == (ctl1_q[7:6] == `CPT_MODE_CMP
         || ctl1_q[7:6] == `CPT_MODE_PWM))
      else $error("pin enable wrong for mode");
   pin_still_a:
      assert property (quiet_q == 3'h7 && ctl1_q[7:4] == 4'h0
         |-> $stable(pin_o))
      else $error("pin moved with action none");
   init_level_a:
      assert property (wr && adr_i == `CPT_ADR_CTRL0 && dat_i[3] && !on_q
         && ctl1_q[7:6] == `CPT_MODE_CMP
         |-> ##3 pin_o == (ctl1_q[3] ^ ctl1_q[2]))
      else $error("pin not at initial level after start");
endmodule

// *** dv/cpt_timer_test.sv ***
// Self-checking testbench for the compact timer.
`timescale 1ns/10ps
`include "cpt_consts.vh"

module cpt_timer_test;
   // PWM table: control byte, compare A, high cycles in 768, A flag.
   localparam [63:0] PWM_C1 = 64'hA8AC_A0AA_A888_98A9;
   localparam [127:0] PWM_A = {16'h0040, 16'h0040, 16'h0040, 16'h0180,
                               16'h0200, 16'h0040, 16'h0040, 16'h0040};
   localparam [79:0] PWM_HI = {10'h0C0, 10'h240, 10'h240, 10'h200,
                               10'h300, 10'h000, 10'h300, 10'h0C0};
   localparam [7:0] PWM_AF = 8'hF7;
   reg         clk_i;
   reg         rst_i;
   reg         ce_i;
   reg         cyc_i;
   reg         stb_i;
   reg         we_i;
   reg  [7:0]  adr_i;
   reg  [3:0]  sel_i;
   reg  [31:0] dat_i;
   wire [31:0] dat_o;
   wire        ack_o;
   wire        pin_o;
   wire        pin_oe_o;
   wire        match_a_flag_o;
   wire        match_p_flag_o;
   integer     n_mismatch;
   integer     n_checks;
   reg  [7:0]  rd;
   reg  [7:0]  rd2;

   cpt_timer DUT (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .ce_i           (ce_i),
      .cyc_i          (cyc_i),
      .stb_i          (stb_i),
      .we_i           (we_i),
      .adr_i          (adr_i),
      .sel_i          (sel_i),
      .dat_i          (dat_i),
      .dat_o          (dat_o),
      .ack_o          (ack_o),
      .sub_tick_i     (1'b0),
      .ext_clk_i      (1'b0),
      .pin_o          (pin_o),
      .pin_oe_o       (pin_oe_o),
      .match_a_flag_o (match_a_flag_o),
      .match_p_flag_o (match_p_flag_o)
   );

   // Free-running 125 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // Verdict and run end.
   task test_done;
      begin
         if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask

   // A wait that runs out counts a mismatch and ends the run.
   task give_up;
      begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected at %0t: wait timed out", $time);
         test_done;
      end
   endtask

   // Compare tasks for wide values and single bits.
   task chkw(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task chk1(input got, input exp);
      begin
         chkw({15'h0000, got}, {15'h0000, exp});
      end
   endtask

   // Wishbone single cycle; holds the request until ack is sampled.
   task bus(input [7:0] a, input w, input [7:0] d);
      integer k;
      begin
         k = 0;
         @(posedge clk_i);
         cyc_i <= 1'b1;
         stb_i <= 1'b1;
         we_i  <= w;
         sel_i <= 4'h1;
         adr_i <= a;
         dat_i <= {24'h00_0000, d};
         @(posedge clk_i);
         while (ack_o !== 1'b1 && k < 16) begin
            @(posedge clk_i);
            k = k + 1;
         end
         rd = dat_o[7:0];
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i  <= 1'b0;
         if (k == 16) begin
            give_up;
         end
      end
   endtask

   // Stop, configure, clear flags and restart at one tick per cycle.
   task setup(input [7:0] c1, input [15:0] a, input [7:0] p);
      begin
         bus(`CPT_ADR_CTRL0, 1'b1, 8'h10);
         bus(`CPT_ADR_CTRL1, 1'b1, c1);
         bus(`CPT_ADR_CMPA_LO, 1'b1, a[7:0]);
         bus(`CPT_ADR_CMPA_HI, 1'b1, a[15:8]);
         bus(`CPT_ADR_PERIOD, 1'b1, p);
         bus(`CPT_ADR_FLAGS, 1'b1, 8'h03);
         bus(`CPT_ADR_CTRL0, 1'b1, 8'h18);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset values, the unmapped slot, a read-only byte and a read-back.
   task t_regs;
      integer i;
      begin
         for (i = 0; i < 9; i = i + 1) begin
            bus(8'(i * 4), 1'b0, 8'h00);
            chkw({8'h00, rd}, 16'h0000);
         end
         bus(`CPT_ADR_CNT_LO, 1'b1, 8'hA5);
         bus(`CPT_ADR_CNT_LO, 1'b0, 8'h00);
         chkw({8'h00, rd}, 16'h0000);
         bus(`CPT_ADR_CMPA_HI, 1'b1, 8'hC3);
         bus(`CPT_ADR_CMPA_HI, 1'b0, 8'h00);
         chkw({8'h00, rd}, 16'h00C3);
      end
   endtask

   // Every action code on a match A; init level opposite where it matters.
   task t_actions;
      integer i;
      integer k;
      reg [1:0] c;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            c = i[1:0];
            k = 0;
            setup({2'b00, c, c != 2'b10, 3'b001}, 16'h0040, 8'h00);
            while (match_a_flag_o !== 1'b1 && k < 400) begin
               @(posedge clk_i);
               k = k + 1;
            end
            if (k == 400) begin
               give_up;
            end
            repeat (3) @(posedge clk_i);
            chk1(pin_o, ~c[0]);
            chk1(match_p_flag_o, 1'b0);
         end
      end
   endtask

   // Clear on P at 256 counts; both flags come up.
   task t_pclear;
      begin
         setup(8'h30, 16'h0080, 8'h01);
         repeat (600) @(posedge clk_i);
         chk1(match_a_flag_o, 1'b1);
         chk1(match_p_flag_o, 1'b1);
         bus(`CPT_ADR_CNT_HI, 1'b0, 8'h00);
         chkw({8'h00, rd}, 16'h0000);
         bus(`CPT_ADR_CNT_LO, 1'b0, 8'h00);
         chkw({8'h00, rd}, 16'h005B);
      end
   endtask

   // Timer mode: pin released, pace, enable, hold, restart, pause.
   task t_timer;
      begin
         setup(8'hC1, 16'h0000, 8'h00);
         repeat (300) @(posedge clk_i);
         bus(`CPT_ADR_CNT_LO, 1'b0, 8'h00);
         rd2 = rd;
         ce_i <= 1'b0;
         repeat (20) @(posedge clk_i);
         ce_i <= 1'b1;
         bus(`CPT_ADR_CNT_LO, 1'b0, 8'h00);
         // Twenty frozen cycles must add no counts.
         chkw({8'h00, rd}, {8'h00, rd2 + 8'h03});
         chk1(pin_oe_o, 1'b0);
         bus(`CPT_ADR_CTRL0, 1'b1, 8'h10);
         bus(`CPT_ADR_CNT_HI, 1'b0, 8'h00);
         chkw({8'h00, rd}, 16'h0001);
         bus(`CPT_ADR_CNT_LO, 1'b0, 8'h00);
         rd2 = rd;
         repeat (20) @(posedge clk_i);
         bus(`CPT_ADR_CNT_LO, 1'b0, 8'h00);
         chkw({8'h00, rd}, {8'h00, rd2});
         bus(`CPT_ADR_CTRL0, 1'b1, 8'h18);
         bus(`CPT_ADR_CNT_HI, 1'b0, 8'h00);
         chkw({8'h00, rd}, 16'h0000);
         bus(`CPT_ADR_CTRL0, 1'b1, 8'h98);
         bus(`CPT_ADR_CNT_LO, 1'b0, 8'h00);
         rd2 = rd;
         repeat (20) @(posedge clk_i);
         bus(`CPT_ADR_CNT_LO, 1'b0, 8'h00);
         chkw({8'h00, rd}, {8'h00, rd2});
      end
   endtask

   // PWM table; 768 cycles is a whole number of both periods used.
   task t_pwm;
      integer i;
      integer j;
      integer hi;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            setup(PWM_C1[63 - 8 * i -: 8], PWM_A[127 - 16 * i -: 16], 8'h01);
            repeat (8) @(posedge clk_i);
            hi = 0;
            for (j = 0; j < 768; j = j + 1) begin
               @(posedge clk_i);
               hi = hi + (pin_o === 1'b1);
            end
            chkw(hi[15:0], {6'h00, PWM_HI[79 - 10 * i -: 10]});
            chk1(match_p_flag_o, 1'b1);
            chk1(match_a_flag_o, PWM_AF[7 - i]);
         end
      end
   endtask

   // Compare A of zero with clear on A: counter wraps, no flags.
   task t_wrap;
      begin
         setup(8'h31, 16'h0000, 8'h00);
         repeat (66000) @(posedge clk_i);
         chk1(match_a_flag_o, 1'b0);
         chk1(match_p_flag_o, 1'b0);
         bus(`CPT_ADR_CNT_HI, 1'b0, 8'h00);
         chkw({8'h00, rd}, 16'h0001);
         chk1(pin_o, 1'b0);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset for ten cycles, then run every scenario.
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'h1;
      dat_i = 32'h0000_0000;
      n_mismatch = 0;
      n_checks = 0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_actions;
      t_pclear;
      t_timer;
      t_pwm;
      t_wrap;
      test_done;
   end
endmodule

bind cpt_timer cpt_timer_monitor u_mon (
   .clk_i          (clk_i),
   .rst_i          (rst_i),
   .ce_i           (ce_i),
   .cyc_i          (cyc_i),
   .stb_i          (stb_i),
   .we_i           (we_i),
   .adr_i          (adr_i),
   .sel_i          (sel_i),
   .dat_i          (dat_i),
   .dat_o          (dat_o),
   .ack_o          (ack_o),
   .pin_o          (pin_o),
   .pin_oe_o       (pin_oe_o),
   .match_a_flag_o (match_a_flag_o),
   .match_p_flag_o (match_p_flag_o)
);

// *** src/cpt_consts.vh ***
// Constants for the compact timer: register map, fields, codes and timing.
`ifndef CPT_CONSTS_VH
`define CPT_CONSTS_VH

// Word-aligned byte addresses of the registers on the 32-bit bus.
`define CPT_ADR_CTRL0      8'h00
`define CPT_ADR_CTRL1      8'h04
`define CPT_ADR_CNT_LO     8'h08
`define CPT_ADR_CNT_HI     8'h0C
`define CPT_ADR_CMPA_LO    8'h10
`define CPT_ADR_CMPA_HI    8'h14
`define CPT_ADR_PERIOD     8'h18
`define CPT_ADR_FLAGS      8'h1C

// Control register zero fields.
`define CPT_C0_PAUSE       7
`define CPT_C0_CKSEL_HI    6
`define CPT_C0_CKSEL_LO    4
`define CPT_C0_ON          3

// Control register one fields.
`define CPT_C1_MODE_HI     7
`define CPT_C1_MODE_LO     6
`define CPT_C1_ACT_HI      5
`define CPT_C1_ACT_LO      4
`define CPT_C1_INIT        3
`define CPT_C1_INV         2
`define CPT_C1_SWAP        1
`define CPT_C1_CLRSEL      0

// Flag register fields.
`define CPT_FL_A           0
`define CPT_FL_P           1

// Reset values.
`define CPT_RST_BYTE       8'h00
`define CPT_RST_WORD       16'h0000

// Operating modes.
`define CPT_MODE_CMP       2'b00
`define CPT_MODE_PWM       2'b10
`define CPT_MODE_TMR       2'b11

// Output action codes.
`define CPT_ACT_NONE       2'b00
`define CPT_ACT_LOW        2'b01
`define CPT_ACT_HIGH       2'b10
`define CPT_ACT_TOGGLE     2'b11

// Counting clock source codes.
`define CPT_CK_SYS4        3'b000
`define CPT_CK_SYS         3'b001
`define CPT_CK_H16         3'b010
`define CPT_CK_H64         3'b011
`define CPT_CK_SUB0        3'b100
`define CPT_CK_SUB1        3'b101
`define CPT_CK_PINR        3'b110
`define CPT_CK_PINF        3'b111

// Prescaler terminal counts, one less than the division ratio.
`define CPT_DIV4_LAST      6'h03
`define CPT_DIV16_LAST     6'h0F
`define CPT_DIV64_LAST     6'h3F

`endif

// *** src/cpt_outpin.v ***
// Output pin logic for compare-match and PWM modes.
`timescale 1ns/10ps
`include "cpt_consts.vh"

module cpt_outpin (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       ce_i,
   input  wire [1:0] mode_i,
   input  wire [1:0] act_i,
   input  wire       init_i,
   input  wire       inv_i,
   input  wire       on_rise_i,
   input  wire       a_evt_i,
   input  wire       pwm_active_i,
   output reg        pin_o,
   output reg        pin_oe_o
);

   reg  lvl_q;
   reg  pwm_lvl;

   // Compare-match pin state; the timer-on rise loads the initial level.
   always @(posedge clk_i) begin
      if (rst_i) begin
         lvl_q <= 1'b0;
      end else if (ce_i) begin
         if (on_rise_i) begin
            lvl_q <= init_i;
         end else if (a_evt_i && mode_i == `CPT_MODE_CMP) begin
            case (act_i)
               `CPT_ACT_LOW:    lvl_q <= 1'b0;
               `CPT_ACT_HIGH:   lvl_q <= 1'b1;
               `CPT_ACT_TOGGLE: lvl_q <= ~lvl_q;
               default:         lvl_q <= lvl_q;
            endcase
         end
      end
   end

   // PWM level: the initial-level bit is the active level.
   always @* begin
      case (act_i)
         `CPT_ACT_NONE: pwm_lvl = ~init_i;
         `CPT_ACT_LOW:  pwm_lvl = init_i;
         `CPT_ACT_HIGH: pwm_lvl = pwm_active_i ? init_i : ~init_i;
         default:       pwm_lvl = ~init_i;
      endcase
   end

   // Registered pin; timer mode leaves the pin undriven for other uses.
   always @(posedge clk_i) begin
      if (rst_i) begin
         pin_o    <= 1'b0;
         pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         pin_o    <= ((mode_i == `CPT_MODE_PWM) ? pwm_lvl : lvl_q) ^ inv_i;
         pin_oe_o <= (mode_i == `CPT_MODE_CMP) ||
                     (mode_i == `CPT_MODE_PWM);
      end
   end

endmodule

// *** src/cpt_tick.v ***
// Counting clock selector: turns the chosen source into one-cycle ticks.
`timescale 1ns/10ps
`include "cpt_consts.vh"

module cpt_tick (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       ce_i,
   input  wire [2:0] sel_i,
   input  wire       sub_tick_i,
   input  wire       ext_clk_i,
   output reg        tick_o
);

   reg  [5:0] pre_q;
   reg        ext_q;

   // Free-running prescaler; the high-speed clock is the system clock here.
   always @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= 6'h00;
         ext_q <= 1'b0;
      end else if (ce_i) begin
         pre_q <= pre_q + 6'h01;
         ext_q <= ext_clk_i;
      end
   end

   // Tick decode; the pin is taken as synchronous, so one stage detects edges.
   always @* begin
      case (sel_i)
         `CPT_CK_SYS4: tick_o = ({4'h0, pre_q[1:0]} == `CPT_DIV4_LAST);
         `CPT_CK_SYS:  tick_o = 1'b1;
         `CPT_CK_H16:  tick_o = ({2'b00, pre_q[3:0]} == `CPT_DIV16_LAST);
         `CPT_CK_H64:  tick_o = (pre_q == `CPT_DIV64_LAST);
         `CPT_CK_SUB0: tick_o = sub_tick_i;
         `CPT_CK_SUB1: tick_o = sub_tick_i;
         `CPT_CK_PINR: tick_o = ext_clk_i & ~ext_q;
         `CPT_CK_PINF: tick_o = ~ext_clk_i & ext_q;
         default:      tick_o = 1'b0;
      endcase
   end

endmodule

// *** src/cpt_timer.v ***
// Compact timer: 16-bit counter, two comparators, Wishbone register file.
//
// What this block does
// - Clear-select high: clear only on match A.
// - Clear-select low: clear on P; overflow if zero.
// - Counter readable as two read-only bytes.
// - Compare A value: two read/write bytes.
// - P compares counter high byte; zero means 65536.
// - Mode 00 compare, 11 timer, 10 PWM.
// - Compare mode, clear-select low: both flags set.
// - Clear-select high outside PWM: P flag never set.
// - A zero, clear-select high: wrap, no flag.
// - Compare mode: only match A moves pin.
// - Action zero leaves pin unchanged.
// - Timer-on rise loads initial pin level.
// - Timer mode counts alike, pin undriven.
// - PWM ignores clear-select; swap bit picks roles.
// - PWM sets each flag on its match.
// - PWM: active level, action, invert.
// - Swap zero: period from P, duty A.
// - Duty not below period: always active.
// - Swap one: period A, duty P times 256.
// - PWM counting continues while pin forced.
// - Timer-on rise zeroes counter; off holds it.
// - Action 01 low, 10 high, 11 toggle.
// - PWM action 00 inactive, 01 active, 10 wave.
`timescale 1ns/10ps
`include "cpt_consts.vh"

module cpt_timer (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire        sub_tick_i,
   input  wire        ext_clk_i,
   output wire        pin_o,
   output wire        pin_oe_o,
   output wire        match_a_flag_o,
   output wire        match_p_flag_o
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   // Counter bytes are read live with no latch, so a 16-bit
   // read may tear while counting; stop the timer first
   // when both halves must agree.
   reg  [7:0]  ctrl0_q;
   reg  [7:0]  ctrl1_q;
   reg  [15:0] cmpa_q;
   reg  [7:0]  per_q;
   reg  [15:0] cnt_q;
   reg  [15:0] cnt_d;
   reg         flag_a_q;
   reg         flag_p_q;
   reg         on_prev_q;
   reg  [7:0]  rd_d;
   reg         pwm_active;

   wire        req;
   wire        wr;
   wire        tick;
   wire        on;
   wire        pause;
   wire [1:0]  mode;
   wire        is_pwm;
   wire        swap;
   wire        clr_sel;
   wire        on_rise;
   wire        run;
   wire [16:0] nxt;
   wire        carry;
   wire        a_hit;
   wire        p_hit;
   wire        clr_by_a;
   wire        hit_clr;
   wire        a_set;
   wire        p_set;
   wire [16:0] period;
   wire [16:0] duty;

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Spans are 17 bits so 65536 does not fold to zero and
   // make every duty look like a full period.
   // Span of the P comparator in counting clocks; zero stands for 65536.
   function [16:0] p_span;
      input [7:0] p;
      begin
         if (p == 8'h00) begin
            p_span = 17'h1_0000;
         end else begin
            p_span = {1'b0, p, 8'h00};
         end
      end
   endfunction

   // Span of the A comparator; zero means the counter runs to its wrap.
   function [16:0] a_span;
      input [15:0] a;
      begin
         if (a == 16'h0000) begin
            a_span = 17'h1_0000;
         end else begin
            a_span = {1'b0, a};
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Field decode.

   // Mode 01 has no meaning here: it counts like compare
   // mode and releases the pin.
   // Control fields pulled out by name.
   assign on      = ctrl0_q[`CPT_C0_ON];
   assign pause   = ctrl0_q[`CPT_C0_PAUSE];
   assign mode    = ctrl1_q[`CPT_C1_MODE_HI:`CPT_C1_MODE_LO];
   assign is_pwm  = (mode == `CPT_MODE_PWM);
   assign swap    = ctrl1_q[`CPT_C1_SWAP];
   assign clr_sel = ctrl1_q[`CPT_C1_CLRSEL];

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave.

   // A request is acknowledged one cycle after it arrives; the write and
   // the read data both belong to the edge at which ack is high, so the
   // master sees the effect exactly when it samples the answer.
   assign req = cyc_i & stb_i;

   // Only byte lane zero carries data; a write without it
   // is acknowledged and dropped.
   assign wr  = req & we_i & ack_o & sel_i[0];

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_o <= req & ~ack_o;
         dat_o <= {24'h00_0000, rd_d};
      end
   end

   // Read multiplexer; unmapped addresses and unused bits read as zero.
   always @* begin
      case (adr_i)
         `CPT_ADR_CTRL0:   rd_d = {ctrl0_q[7:3], 3'b000};
         `CPT_ADR_CTRL1:   rd_d = ctrl1_q;
         `CPT_ADR_CNT_LO:  rd_d = cnt_q[7:0];
         `CPT_ADR_CNT_HI:  rd_d = cnt_q[15:8];
         `CPT_ADR_CMPA_LO: rd_d = cmpa_q[7:0];
         `CPT_ADR_CMPA_HI: rd_d = cmpa_q[15:8];
         `CPT_ADR_PERIOD:  rd_d = per_q;
         `CPT_ADR_FLAGS:   rd_d = {6'h00, flag_p_q, flag_a_q};
         default:          rd_d = 8'h00;
      endcase
   end

   // Control register zero bits 2 to 0 are not implemented: writes drop
   // them and reads return zero.
   // Software-writable registers; the counter bytes take no writes.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl0_q <= `CPT_RST_BYTE;
         ctrl1_q <= `CPT_RST_BYTE;
         cmpa_q  <= `CPT_RST_WORD;
         per_q   <= `CPT_RST_BYTE;
      end else if (ce_i && wr) begin
         case (adr_i)
            `CPT_ADR_CTRL0:   ctrl0_q <= {dat_i[7:3], 3'b000};
            `CPT_ADR_CTRL1:   ctrl1_q <= dat_i[7:0];
            `CPT_ADR_CMPA_LO: cmpa_q[7:0]  <= dat_i[7:0];
            `CPT_ADR_CMPA_HI: cmpa_q[15:8] <= dat_i[7:0];
            `CPT_ADR_PERIOD:  per_q   <= dat_i[7:0];
            default:          ctrl0_q <= ctrl0_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counting clock.

   // The clock-select field picks the tick source.
   cpt_tick u_tick (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .sel_i      (ctrl0_q[`CPT_C0_CKSEL_HI:`CPT_C0_CKSEL_LO]),
      .sub_tick_i (sub_tick_i),
      .ext_clk_i  (ext_clk_i),
      .tick_o     (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Counter and comparators.

   // A start: the write lands at edge W, on_rise is high in
   // the next cycle, the counter is zero at W+1 and counts
   // first at W+2. A tick in the on_rise cycle is dropped
   // so every start begins from a clean zero.
   // Timer-on edge, seen one cycle after the control write lands.
   always @(posedge clk_i) begin
      if (rst_i) begin
         on_prev_q <= 1'b0;
      end else if (ce_i) begin
         on_prev_q <= on;
      end
   end
   // High for the one cycle after timer-on is set.
   assign on_rise = on & ~on_prev_q;

   // Matches are judged on the value the counter is about to take, so a
   // compare value N ends a cycle of exactly N counting clocks.
   assign run   = on & ~pause & tick & ~on_rise;
   assign nxt   = {1'b0, cnt_q} + 17'h0_0001;
   assign carry = nxt[16];
   assign p_hit = (per_q == 8'h00) ? carry :
                  (nxt[15:8] == per_q) && (nxt[7:0] == 8'h00);
   // A zero compare A value never matches; the count wraps.
   assign a_hit = (cmpa_q != 16'h0000) && !carry &&
                  (nxt[15:0] == cmpa_q);

   // A zero period byte makes p_hit the overflow, so the P
   // flag marks the wrap when P clears the counter.
   // PWM uses the swap bit to pick the period comparator instead.
   assign clr_by_a = is_pwm ? swap : clr_sel;
   assign hit_clr  = clr_by_a ? a_hit : p_hit;

   // Next counter value; turning the timer off simply stops the ticks.
   // Pause acts through run too, so the count is kept.
   always @* begin
      if (on_rise) begin
         cnt_d = 16'h0000;
      end else if (run && hit_clr) begin
         cnt_d = 16'h0000;
      end else if (run) begin
         cnt_d = nxt[15:0];
      end else begin
         cnt_d = cnt_q;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= `CPT_RST_WORD;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Match flags.

   // With clear-select high outside PWM the P comparator raises nothing,
   // even when its value lies below the A value.
   assign a_set = run & a_hit;
   assign p_set = run & p_hit & (is_pwm | ~clr_sel);

   // Each flag clears on its own bit of the write.
   // Sticky flags, cleared by writing one; a match in the same cycle as
   // the clear wins so no event is lost.
   always @(posedge clk_i) begin
      if (rst_i) begin
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
      end else if (ce_i) begin
         if (a_set) begin
            flag_a_q <= 1'b1;
         end else if (wr && adr_i == `CPT_ADR_FLAGS &&
                      dat_i[`CPT_FL_A]) begin
            flag_a_q <= 1'b0;
         end
         if (p_set) begin
            flag_p_q <= 1'b1;
         end else if (wr && adr_i == `CPT_ADR_FLAGS &&
                      dat_i[`CPT_FL_P]) begin
            flag_p_q <= 1'b0;
         end
      end
   end

   // Flags leave straight from their flip-flops, so the
   // pins and the flag byte always agree.
   assign match_a_flag_o = flag_a_q;
   assign match_p_flag_o = flag_p_q;

   ////////////////////////////////////////////////////////////////////////
   // PWM duty.

   // Period and duty spans by the swap bit; the comparison keeps running
   // whatever the action field does to the pin.
   assign period = swap ? a_span(cmpa_q) : p_span(per_q);
   assign duty   = swap ? p_span(per_q) : {1'b0, cmpa_q};

   // Duty is judged on the live counter, so a change made
   // while running acts mid-period; stop the timer before
   // changing duty or period.
   // Active from counter zero until the duty count is reached; a duty at
   // or beyond the period keeps the wave active for the whole period.
   always @* begin
      if (duty >= period) begin
         pwm_active = 1'b1;
      end else begin
         pwm_active = ({1'b0, cnt_q} < duty);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pin.

   // The pin is registered in the child and trails the
   // flags by one clock; the latency buys a pin free of
   // glitches from the compare logic.
   // Only a counted A match steers the compare-mode pin.
   cpt_outpin u_out (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .ce_i         (ce_i),
      .mode_i       (mode),
      .act_i        (ctrl1_q[`CPT_C1_ACT_HI:`CPT_C1_ACT_LO]),
      .init_i       (ctrl1_q[`CPT_C1_INIT]),
      .inv_i        (ctrl1_q[`CPT_C1_INV]),
      .on_rise_i    (on_rise),
      .a_evt_i      (a_set),
      .pwm_active_i (pwm_active),
      .pin_o        (pin_o),
      .pin_oe_o     (pin_oe_o)
   );

endmodule
